// >>> design/dioc_channel.v
// Direct input/output channel: order sequencer, handshakes and discretes
// ==========================================
// Overview of operation
// R01: Six program orders drive every channel action
// R02: Select order connects one device to input bus
// R03: Select order presents a free 15-bit field
// R04: Outside logic may split field nine/six bits
// R05: Select order emits a readiness strobe
// R06: Device acknowledges while strobe is still active
// R07: Accepted acknowledge returns a response signal
// R08: No acknowledge in window requests a skip
// R09: Data input handshakes, then stores bus word
// R10: Software selects a device before data input
// R11: Selection holds until the next select order
// R12: Discrete skips skip when signal is clear
// R13: One-hot address bit picks the tested point
// R14: Internal skip senses six test-panel lines
// R15: Output devices share one bus and select
// R16: Data output drives word, strobes, gets acknowledge
// R17: Pulse order sends one-microsecond pulse to point
// R18: Fifteen pulse points direct; more by decoding
// R19: Bidirectional device is reselected between directions
// R20: Transfer register holds the output bus word
// R21: Select order clears latched interrupt requests
// R22: Strobe window length is a parameter
`timescale 1ns/10ps
`include "dioc_defs.vh"
module dioc_channel
#(
   parameter STROBE_CYC = `DIOC_STROBE_CYC,
   parameter FIFO_DEPTH = `DIOC_FIFO_DEPTH
)
(
   // Clock, reset, enable
   input wire CLK_SYS,
   input wire SRST,
   input wire CE,
   // Order port from the processor
   input wire ORD_VALID,
   input wire [`DIOC_ORD_W-1:0] ORD_CODE,
   input wire [`DIOC_FIELD_W-1:0] ORD_FIELD,
   input wire [`DIOC_WORD_W-1:0] ORD_WORD,
   output reg ORD_READY,
   output reg ORD_DONE,
   output reg ORD_SKIP,
   // Input words toward memory
   output reg IN_VALID,
   input wire IN_READY,
   output reg [`DIOC_WORD_W-1:0] IN_WORD,
   // Device link
   output reg [`DIOC_FIELD_W-1:0] SEL_FIELD,
   output reg SEL_STROBE,
   output reg IN_STROBE,
   output reg OUT_STROBE,
   input wire DEV_ACK,
   output reg RESP_ACK,
   input wire [`DIOC_WORD_W-1:0] IN_BUS,
   output reg [`DIOC_WORD_W-1:0] OUT_BUS,
   // Discretes
   input wire [`DIOC_FIELD_W-1:0] EXT_DISC,
   input wire [`DIOC_INT_W-1:0] INT_DISC,
   output reg [`DIOC_FIELD_W-1:0] PULSE_OUT,
   // Interrupt request latches
   input wire [`DIOC_IRQ_W-1:0] IRQ_IN,
   output reg [`DIOC_IRQ_W-1:0] IRQ_LATCHED
);
   // ==========================================
   // States
   localparam ST_IDLE = 3'h0;
   localparam ST_STROBE = 3'h1;
   localparam ST_RESP = 3'h2;
   localparam ST_PULSE = 3'h3;
   localparam ST_WAIT = 3'h4;

   reg [2:0] state;
   reg [`DIOC_ORD_W-1:0] cur_ord;
   reg [15:0] timer;
   reg [`DIOC_FIELD_W-1:0] cur_field;
   reg [`DIOC_WORD_W-1:0] xfer_reg;
   reg ack_s1;
   reg ack_s2;
   reg [`DIOC_WORD_W-1:0] bus_s1;
   reg [`DIOC_WORD_W-1:0] bus_s2;
   reg [`DIOC_FIELD_W-1:0] ext_s1;
   reg [`DIOC_FIELD_W-1:0] ext_s2;
   reg [`DIOC_INT_W-1:0] int_s1;
   reg [`DIOC_INT_W-1:0] int_s2;
   reg [`DIOC_IRQ_W-1:0] irq_s1;
   reg [`DIOC_IRQ_W-1:0] irq_s2;
   reg fifo_push;
   reg [`DIOC_WORD_W-1:0] fifo_din;
   wire fifo_ready;
   wire fifo_valid;
   wire [`DIOC_WORD_W-1:0] fifo_dout;
   wire pop_now;

   // Discrete point sensed: set if any field bit names a set signal
   function sensed;
      input [`DIOC_FIELD_W-1:0] sel;
      input [`DIOC_FIELD_W-1:0] sig;
      begin
         sensed = |(sel & sig);
      end
   endfunction

   // ==========================================
   // Synchronisers for all pin inputs
   always @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         bus_s1 <= {`DIOC_WORD_W{1'b0}};
         bus_s2 <= {`DIOC_WORD_W{1'b0}};
         ext_s1 <= {`DIOC_FIELD_W{1'b0}};
         ext_s2 <= {`DIOC_FIELD_W{1'b0}};
         int_s1 <= {`DIOC_INT_W{1'b0}};
         int_s2 <= {`DIOC_INT_W{1'b0}};
         irq_s1 <= {`DIOC_IRQ_W{1'b0}};
         irq_s2 <= {`DIOC_IRQ_W{1'b0}};
      end
      else if (CE)
      begin
         ack_s1 <= DEV_ACK;
         ack_s2 <= ack_s1;
         bus_s1 <= IN_BUS;
         bus_s2 <= bus_s1;
         ext_s1 <= EXT_DISC;
         ext_s2 <= ext_s1;
         int_s1 <= INT_DISC;
         int_s2 <= int_s1;
         irq_s1 <= IRQ_IN;
         irq_s2 <= irq_s1;
      end
   end

   // ==========================================
   // Input word buffer toward memory
   // Stalls data input orders when memory writes lag behind
   dioc_fifo
   #(
      .WIDTH(`DIOC_WORD_W),
      .DEPTH(FIFO_DEPTH),
      .AW(2)
   )
   u_fifo
   (
      .clk(CLK_SYS),
      .srst(SRST),
      .ce(CE),
      .in_valid(fifo_push),
      .in_ready(fifo_ready),
      .in_data(fifo_din),
      .out_valid(fifo_valid),
      .out_ready(pop_now),
      .out_data(fifo_dout)
   );

   // Output stage register takes a word when empty or being drained
   assign pop_now = fifo_valid && (!IN_VALID || IN_READY);

   always @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         IN_VALID <= 1'b0;
         IN_WORD <= {`DIOC_WORD_W{1'b0}};
      end
      else if (CE)
      begin
         if (pop_now)
         begin
            IN_VALID <= 1'b1;
            IN_WORD <= fifo_dout;
         end
         else if (IN_READY)
            IN_VALID <= 1'b0;
      end
   end

   // ==========================================
   // Order sequencer
   always @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         state <= ST_IDLE;
         cur_ord <= `DIOC_ORD_SKIP_INT;
         cur_field <= {`DIOC_FIELD_W{1'b0}};
         timer <= 16'h0000;
         xfer_reg <= {`DIOC_WORD_W{1'b0}};
         ORD_READY <= 1'b0;
         ORD_DONE <= 1'b0;
         ORD_SKIP <= 1'b0;
         SEL_FIELD <= {`DIOC_FIELD_W{1'b0}};
         SEL_STROBE <= 1'b0;
         IN_STROBE <= 1'b0;
         OUT_STROBE <= 1'b0;
         RESP_ACK <= 1'b0;
         OUT_BUS <= {`DIOC_WORD_W{1'b0}};
         PULSE_OUT <= {`DIOC_FIELD_W{1'b0}};
         IRQ_LATCHED <= {`DIOC_IRQ_W{1'b0}};
         fifo_push <= 1'b0;
         fifo_din <= {`DIOC_WORD_W{1'b0}};
      end
      else if (CE)
      begin
         ORD_DONE <= 1'b0;
         ORD_SKIP <= 1'b0;
         fifo_push <= 1'b0;
         // Latch requests; a new level wins over the clear of this cycle
         IRQ_LATCHED <= IRQ_LATCHED | irq_s2;
         case (state)
            ST_IDLE:
            begin
               ORD_READY <= 1'b1;
               if (ORD_VALID && ORD_READY)
               begin
                  ORD_READY <= 1'b0;
                  cur_ord <= ORD_CODE;
                  cur_field <= ORD_FIELD;
                  timer <= 16'h0000;
                  case (ORD_CODE) // see R01
                     `DIOC_ORD_SKIP_EXT:
                     begin
                        ORD_DONE <= 1'b1;
                        ORD_SKIP <= !sensed(ORD_FIELD, ext_s2); // see R12 see R13
                        state <= ST_WAIT;
                     end
                     `DIOC_ORD_SKIP_INT:
                     begin
                        ORD_DONE <= 1'b1;
                        // Test-panel lines only; field bits above them sense zero
                        ORD_SKIP <= !sensed(ORD_FIELD,
                           {{(`DIOC_FIELD_W-`DIOC_INT_W){1'b0}}, int_s2}); // see R12 see R14
                        state <= ST_WAIT;
                     end
                     `DIOC_ORD_PULSE:
                     begin
                        PULSE_OUT <= ORD_FIELD; // see R17 see R18
                        state <= ST_PULSE;
                     end
                     `DIOC_ORD_SELECT:
                     begin
                        SEL_FIELD <= ORD_FIELD; // see R02 see R03 see R11 see R15 see R19
                        SEL_STROBE <= 1'b1; // see R05
                        IRQ_LATCHED <= irq_s2; // see R21
                        state <= ST_STROBE;
                     end
                     `DIOC_ORD_DATA_IN:
                     begin
                        IN_STROBE <= 1'b1; // see R09
                        state <= ST_STROBE;
                     end
                     `DIOC_ORD_DATA_OUT:
                     begin
                        xfer_reg <= ORD_WORD; // see R20
                        OUT_BUS <= ORD_WORD; // see R16
                        OUT_STROBE <= 1'b1;
                        state <= ST_STROBE;
                     end
                     default:
                     begin
                        ORD_DONE <= 1'b1;
                        state <= ST_WAIT;
                     end
                  endcase
               end
            end
            ST_STROBE:
            begin
               // Data input with a full buffer waits here only until the window closes, then skips
               if (ack_s2 && (cur_ord != `DIOC_ORD_DATA_IN || fifo_ready))
               begin
                  SEL_STROBE <= 1'b0;
                  IN_STROBE <= 1'b0;
                  OUT_STROBE <= 1'b0;
                  RESP_ACK <= 1'b1; // see R07
                  if (cur_ord == `DIOC_ORD_DATA_IN)
                  begin
                     fifo_din <= bus_s2; // see R09
                     fifo_push <= 1'b1;
                  end
                  state <= ST_RESP;
               end
               else if (timer == STROBE_CYC - 1) // see R22
               begin
                  // Late acknowledge is ignored once the window closes
                  SEL_STROBE <= 1'b0;
                  IN_STROBE <= 1'b0;
                  OUT_STROBE <= 1'b0;
                  ORD_DONE <= 1'b1;
                  ORD_SKIP <= 1'b1; // see R08 see R06
                  state <= ST_WAIT;
               end
               else
                  timer <= timer + 16'h0001;
            end
            ST_RESP:
            begin
               RESP_ACK <= 1'b0;
               ORD_DONE <= 1'b1;
               state <= ST_WAIT;
            end
            ST_PULSE:
            begin
               if (timer == `DIOC_PULSE_CYC - 1)
               begin
                  PULSE_OUT <= {`DIOC_FIELD_W{1'b0}}; // see R17
                  ORD_DONE <= 1'b1;
                  state <= ST_WAIT;
               end
               else
                  timer <= timer + 16'h0001;
            end
            ST_WAIT:
            begin
               // One idle cycle so ORD_READY returns before next order
               state <= ST_IDLE;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end
endmodule

// >>> include/dioc_defs.vh
// Constants for the direct input/output channel
`ifndef DIOC_DEFS_VH
`define DIOC_DEFS_VH
// ==========================================
// Order codes
`define DIOC_ORD_W 3
`define DIOC_ORD_SKIP_INT 3'h0
`define DIOC_ORD_SKIP_EXT 3'h1
`define DIOC_ORD_PULSE 3'h2
`define DIOC_ORD_SELECT 3'h3
`define DIOC_ORD_DATA_IN 3'h4
`define DIOC_ORD_DATA_OUT 3'h5
// ==========================================
// Field widths
`define DIOC_FIELD_W 15
`define DIOC_WORD_W 24
`define DIOC_INT_W 6
`define DIOC_IRQ_W 8
// ==========================================
// Timing
`define DIOC_CLK_MHZ 125
`define DIOC_PULSE_NS 1000
`define DIOC_PERIOD_NS 8
`define DIOC_PULSE_CYC (`DIOC_PULSE_NS / `DIOC_PERIOD_NS)
`define DIOC_STROBE_CYC 16
`define DIOC_FIFO_DEPTH 4
`endif

// >>> design/dioc_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module dioc_fifo
#(
   parameter WIDTH = 24,
   parameter DEPTH = 4,
   parameter AW = 2
)
(
   // Clock and control
   input wire clk,
   input wire srst,
   input wire ce,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   function [AW-1:0] ptr_inc;
      input [AW-1:0] p;
      begin
         if (p == DEPTH - 1)
            ptr_inc = {AW{1'b0}};
         else
            ptr_inc = p + 1'b1;
      end
   endfunction

   assign in_ready = (count != DEPTH);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = ce && in_valid && in_ready;
   assign pop = ce && out_valid && out_ready;

   always @(posedge clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always @(posedge clk)
   begin
      if (srst)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= ptr_inc(wr_ptr);
         if (pop)
            rd_ptr <= ptr_inc(rd_ptr);
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule

// >>> tb/dioc_chan_sva.sv
// Port assertions for the direct input/output channel
`timescale 1ns/10ps
`include "dioc_defs.vh"
module dioc_chan_sva
#(
   parameter int STROBE_CYC = 16
)
(
   // Order port
   input wire CLK_SYS,
   input wire SRST,
   input wire ORD_VALID,
   input wire [`DIOC_ORD_W-1:0] ORD_CODE,
   input wire [`DIOC_FIELD_W-1:0] ORD_FIELD,
   input wire [`DIOC_WORD_W-1:0] ORD_WORD,
   input wire ORD_READY,
   input wire ORD_DONE,
   input wire ORD_SKIP,
   // Device link
   input wire [`DIOC_FIELD_W-1:0] SEL_FIELD,
   input wire SEL_STROBE,
   input wire OUT_STROBE,
   input wire IN_STROBE,
   input wire RESP_ACK,
   input wire [`DIOC_WORD_W-1:0] OUT_BUS
);
   wire take = ORD_VALID && ORD_READY;
   reg [7:0] cnt;
   reg [2:0] code_q;
   // Cycle count since the last take; only read at completion, so no reset needed
   always @(posedge CLK_SYS)
   begin
      cnt <= take ? 8'h01 : cnt + 8'h01;
      if (take)
         code_q <= ORD_CODE;
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   // ====================
   // Assertions
   sel_load_a: assert property (take && ORD_CODE == `DIOC_ORD_SELECT |=>
      SEL_FIELD == $past(ORD_FIELD)) else $error("select field wrong");
   sel_hold_a: assert property (!(take && ORD_CODE == `DIOC_ORD_SELECT) |=>
      $stable(SEL_FIELD)) else $error("selection moved");
   sel_strobe_a: assert property (take && ORD_CODE == `DIOC_ORD_SELECT |=> SEL_STROBE)
      else $error("no select strobe");
   out_word_a: assert property (take && ORD_CODE == `DIOC_ORD_DATA_OUT |=>
      OUT_STROBE && OUT_BUS == $past(ORD_WORD)) else $error("output word wrong");
   in_strobe_a: assert property (take && ORD_CODE == `DIOC_ORD_DATA_IN |=> IN_STROBE)
      else $error("no input strobe");
   resp_done_a: assert property (RESP_ACK |=> ORD_DONE && !ORD_SKIP)
      else $error("response without completion");
   timeout_skip_a: assert property (ORD_SKIP && code_q >= `DIOC_ORD_SELECT |->
      cnt == STROBE_CYC + 1) else $error("skip not at window end");
   disc_time_a: assert property (ORD_DONE && code_q <= `DIOC_ORD_SKIP_EXT |->
      cnt == 8'h01) else $error("discrete finish wrong");
   pulse_time_a: assert property (ORD_DONE && code_q == `DIOC_ORD_PULSE |->
      cnt == `DIOC_PULSE_CYC + 1) else $error("pulse length wrong");
endmodule
bind dioc_channel dioc_chan_sva #(.STROBE_CYC(STROBE_CYC)) i_dioc_chan_sva (.CLK_SYS(CLK_SYS),
   .SRST(SRST), .ORD_VALID(ORD_VALID), .ORD_CODE(ORD_CODE), .ORD_FIELD(ORD_FIELD),
   .ORD_WORD(ORD_WORD), .ORD_READY(ORD_READY), .ORD_DONE(ORD_DONE), .ORD_SKIP(ORD_SKIP),
   .SEL_FIELD(SEL_FIELD), .SEL_STROBE(SEL_STROBE), .OUT_STROBE(OUT_STROBE),
   .IN_STROBE(IN_STROBE), .RESP_ACK(RESP_ACK), .OUT_BUS(OUT_BUS));

// >>> tb/dioc_dev_model.sv
// Behavioural peripheral that answers the channel strobes
`timescale 1ns/10ps
module dioc_dev_model
(
   // Channel side
   input wire clk,
   input wire strobe,
   input wire in_strobe,
   input wire out_strobe,
   input wire [14:0] sel_field,
   input wire [23:0] out_bus,
   output reg dev_ack = 1'b0,
   output reg [23:0] in_bus = 24'h000000,
   // Bench control
   input wire [8:0] addr,
   input wire [7:0] delay,
   input wire [23:0] word,
   output reg [23:0] got = 24'h000000
);
   reg [7:0] n = 8'h00;
   always @(posedge clk)
   begin
      // A released bus must not keep showing the last word
      in_bus <= in_strobe ? word : ~in_bus;
      if (!strobe || sel_field[8:0] != addr)
      begin
         n <= 8'h00;
         dev_ack <= 1'b0;
      end
      else if (n == delay)
      begin
         dev_ack <= 1'b1;
         got <= out_strobe ? out_bus : got;
      end
      else
         n <= n + 8'h01;
   end
endmodule

// >>> tb/testbench.sv
// Self-checking testbench for the direct input/output channel
`timescale 1ns/10ps
`include "dioc_defs.vh"
module testbench;
   localparam int SC = 8;
   logic CLK_SYS = 1'b0, SRST = 1'b1, ORD_VALID = 1'b0, IN_READY = 1'b1, CE = 1'b1, skip;
   logic ORD_READY, ORD_DONE, ORD_SKIP, IN_VALID, SEL_STROBE, IN_STROBE, OUT_STROBE;
   logic DEV_ACK, RESP_ACK;
   logic [2:0] ORD_CODE = 3'h0;
   logic [5:0] INT_DISC = 6'h00;
   logic [7:0] IRQ_IN = 8'hA5, IRQ_LATCHED, delay = 8'h00;
   logic [7:0] dl[3] = '{8'h00, 8'h03, 8'h06};
   logic [14:0] ORD_FIELD = 15'h0000, EXT_DISC = 15'h0000, SEL_FIELD, PULSE_OUT, f;
   logic [23:0] ORD_WORD = 24'h000000, IN_WORD, IN_BUS, OUT_BUS, got, w;
   logic [23:0] q[$];
   int fails = 0, check_count = 0, pw = 0, resp_n = 0, b;
   always #4 CLK_SYS = ~CLK_SYS;
   dioc_channel #(.STROBE_CYC(SC), .FIFO_DEPTH(4)) i_dioc_channel (.CLK_SYS(CLK_SYS),
      .SRST(SRST), .CE(CE), .ORD_VALID(ORD_VALID), .ORD_CODE(ORD_CODE), .ORD_FIELD(ORD_FIELD),
      .ORD_WORD(ORD_WORD), .ORD_READY(ORD_READY), .ORD_DONE(ORD_DONE), .ORD_SKIP(ORD_SKIP),
      .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_WORD(IN_WORD), .SEL_FIELD(SEL_FIELD),
      .SEL_STROBE(SEL_STROBE), .IN_STROBE(IN_STROBE), .OUT_STROBE(OUT_STROBE), .DEV_ACK(DEV_ACK),
      .RESP_ACK(RESP_ACK), .IN_BUS(IN_BUS), .OUT_BUS(OUT_BUS), .EXT_DISC(EXT_DISC),
      .INT_DISC(INT_DISC), .PULSE_OUT(PULSE_OUT), .IRQ_IN(IRQ_IN), .IRQ_LATCHED(IRQ_LATCHED));
   dioc_dev_model i_dioc_dev_model (.clk(CLK_SYS), .strobe(SEL_STROBE | IN_STROBE | OUT_STROBE),
      .in_strobe(IN_STROBE), .out_strobe(OUT_STROBE), .sel_field(SEL_FIELD), .out_bus(OUT_BUS),
      .dev_ack(DEV_ACK), .in_bus(IN_BUS), .addr(9'h005), .delay(delay), .word(ORD_WORD), .got(got));
   task automatic chk(input logic [23:0] a, input logic [23:0] e);
      check_count++;
      if (a !== e)
      begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, a, e);
      end
   endtask
   task automatic chk1(input logic a, input logic e);
      chk({23'h000000, a}, {23'h000000, e});
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLK_SYS);
      #1;
   endtask
   // Present one order, hold it to the taking edge, then wait for completion
   task automatic order(input logic [2:0] c, input logic [14:0] fl, input logic [23:0] wd,
      input logic [7:0] d);
      int n;
      tick(1);
      ORD_CODE = c;
      ORD_FIELD = fl;
      ORD_WORD = wd;
      delay = d;
      ORD_VALID = 1'b1;
      for (n = 0; ORD_READY !== 1'b1 && n < 50; n++)
         tick(1);
      if (ORD_READY !== 1'b1)
      begin
         fails++;
         end_of_test;
      end
      tick(1);
      ORD_VALID = 1'b0;
      for (n = 0; ORD_DONE !== 1'b1 && n < 300; n++)
         @(negedge CLK_SYS);
      skip = ORD_SKIP;
      if (ORD_DONE !== 1'b1)
      begin
         fails++;
         end_of_test;
      end
   endtask
   always @(negedge CLK_SYS)
   begin
      if (PULSE_OUT !== 15'h0000)
         pw <= pw + ((PULSE_OUT === ORD_FIELD) ? 1 : 1000);
      if (RESP_ACK === 1'b1)
         resp_n <= resp_n + 1;
      if (IN_VALID === 1'b1 && IN_READY)
         chk(IN_WORD, q.pop_front());
   end
   initial
   begin
      w = $urandom(58);
      tick(6);
      SRST = 1'b0;
      chk({ORD_READY, IN_VALID, RESP_ACK, PULSE_OUT}, 24'h000000);
      f = {w[5:0], 9'h005};
      order(3'h3, f, 24'h000000, 8'h00);
      chk1(skip, 1'b0);
      chk(24'(resp_n), 24'h000001);
      chk(SEL_FIELD, f);
      chk(IRQ_LATCHED, 8'hA5);
      tick(1);
      IRQ_IN = 8'h00;
      tick(4);
      chk(IRQ_LATCHED, 8'hA5);
      order(3'h3, f, 24'h000000, 8'h00);
      chk(IRQ_LATCHED, 8'h00);
      // Enable low must freeze the request latches and their synchronisers
      tick(1);
      CE = 1'b0;
      IRQ_IN = 8'h5A;
      tick(5);
      chk(IRQ_LATCHED, 8'h00);
      CE = 1'b1;
      tick(4);
      chk(IRQ_LATCHED, 8'h5A);
      $display("test select done");
      // Prompt, slow and too-late answers against the strobe window
      foreach (dl[i])
      begin
         order(3'h3, f, 24'h000000, dl[i]);
         chk1(skip, dl[i] > SC - 4);
      end
      order(3'h3, f ^ 15'h0001, 24'h000000, 8'h00);
      chk1(skip, 1'b1);
      order(3'h6, f, 24'h000000, 8'h00);
      chk1(skip, 1'b0);
      $display("test handshake done");
      order(3'h3, f, 24'h000000, 8'h00);
      tick(1);
      IN_READY = 1'b0;
      repeat (4)
      begin
         w = $urandom;
         q.push_back(w);
         order(3'h4, f, w, 8'h02);
         chk1(skip, 1'b0);
      end
      chk(SEL_FIELD, f);
      tick(1);
      IN_READY = 1'b1;
      tick(12);
      chk(24'(q.size()), 24'h000000);
      order(3'h3, f, 24'h000000, 8'h00);
      w = $urandom;
      order(3'h5, f, w, 8'h03);
      chk1(skip, 1'b0);
      chk(OUT_BUS, w);
      chk(got, w);
      $display("test data done");
      for (b = 0; b < 15; b++)
      begin
         tick(1);
         EXT_DISC = 15'($urandom);
         INT_DISC = 6'($urandom);
         tick(3);
         order(3'h1, 15'h0001 << b, 24'h000000, 8'h00);
         chk1(skip, !EXT_DISC[b]);
         order(3'h0, 15'h0001 << (b % 6), 24'h000000, 8'h00);
         chk1(skip, !INT_DISC[b % 6]);
      end
      b = $urandom_range(14);
      pw = 0;
      order(3'h2, 15'h0001 << b, 24'h000000, 8'h00);
      tick(4);
      chk(24'(pw), 24'(`DIOC_PULSE_CYC));
      $display("test discretes done");
      end_of_test;
   end
endmodule
